// ==== design/adccs_consts.svh ====
// Constants of the channel sequencer: field positions, codes, timing.
// Summary of operation
// - Scan singles or pairs, optional temperature slot
// - Scan runs from input 0 to last field
// - Scanned pairs: even input positive, odd input negative
// - High data at bit 13 starts update
// - Mode 01 updates settings without stopping scan
// - Pairing or last-channel change restarts scan
// - Bit 6 picks full or quarter bandwidth
// - Internal reference gives 2.5V or 4.096V
// - Internal reference also enables temperature sensor
// - Temperature results are straight binary codes
// - Six reference schemes, two buffered external
// - Mode field: off, update, scan+temp, scan
// - Load on 14th falling edge, then lock
`ifndef ADCCS_CONSTS_SVH
`define ADCCS_CONSTS_SVH

// Configuration word layout
`define ADCCS_CFG_W 14
`define ADCCS_CFG_RST 14'h3fff
`define ADCCS_OVR_BIT 13
`define ADCCS_INPUT_CONFIG_FIELD_HI 12
`define ADCCS_INPUT_CONFIG_FIELD_LO 10
`define ADCCS_PAIR_BIT 11
`define ADCCS_LAST_HI 9
`define ADCCS_LAST_LO 7
`define ADCCS_BW_BIT 6
`define ADCCS_REF_HI 5
`define ADCCS_REF_LO 3
`define ADCCS_SEQ_HI 2
`define ADCCS_SEQ_LO 1
`define ADCCS_RB_BIT 0

// Input configuration codes
`define ADCCS_INPUT_CONFIG_FIELD_TEMP 3'h3
`define ADCCS_INPUT_CONFIG_FIELD_GND 3'h7

// Reference scheme codes
`define ADCCS_REF_INT2V5 3'h0
`define ADCCS_REF_INT4V096 3'h1
`define ADCCS_REF_EXT_T 3'h2
`define ADCCS_REF_EXTBUF_T 3'h3
`define ADCCS_REF_EXT 3'h6
`define ADCCS_REF_EXTBUF 3'h7

// Sequencer mode codes
`define ADCCS_SEQ_OFF 2'h0
`define ADCCS_SEQ_UPD 2'h1
`define ADCCS_SEQ_SCANT 2'h2
`define ADCCS_SEQ_SCAN 2'h3

// Timing
`define ADCCS_CNT_W 12
`define ADCCS_CLK_NS 40
`define ADCCS_TCONV_MAX_NS 2200
`define ADCCS_TCONV_CYC \
  ((`ADCCS_TCONV_MAX_NS + `ADCCS_CLK_NS - 1) / `ADCCS_CLK_NS)

`endif

// ==== design/adccs_pkg.sv ====
// Types of the channel sequencer.
`default_nettype none
`include "adccs_consts.svh"
package adccs_pkg;

  // Conversion state, one bit so Gray trivially
  typedef enum logic {
    ADCCS_IDLE = 1'b0,
    ADCCS_CONV = 1'b1
  } adccs_conv_t;

  // Serial loader state
  typedef struct packed {
    logic [3:0] cnt;
    logic [`ADCCS_CFG_W-1:0] sh;
    logic take;
    logic load;
  } adccs_shift_t;

  // Main state
  typedef struct packed {
    logic cnv_s1, cnv_s2, cnv_s3;
    logic sck_s1, sck_s2, sck_s3;
    logic din_s1, din_s2;
    adccs_conv_t st;
    logic [`ADCCS_CNT_W-1:0] cnt;
    logic [`ADCCS_CFG_W-1:0] cfg;
    logic [`ADCCS_CFG_W-1:0] pend;
    logic pend_v;
    logic locked;
    logic [1:0] mode;
    logic [2:0] chan;
    logic tslot;
    logic restarted;
    logic [2:0] pos;
    logic [2:0] neg;
    logic neg_pair;
    logic neg_com;
    logic temp_sel;
    logic quarter_bw;
    logic [3:0] refd;
    logic straight;
  } adccs_state_t;

endpackage
`default_nettype wire

// ==== design/adccs_cfg_shift.sv ====
// Serial loader for the 14-bit configuration word.
`timescale 1ns/10ps
`default_nettype none
`include "adccs_consts.svh"
module adccs_cfg_shift
  import adccs_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic frame,
  input wire logic sck_fall,
  input wire logic din,
  input wire logic lock,
  output logic load,
  output logic [`ADCCS_CFG_W-1:0] word
);

  adccs_shift_t q, d; // Loader state and next value
  logic take; // Word accepted this frame

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    take = q.take;
    d.load = 1'b0;
    if (frame) begin
      // New frame, look at the first edge again
      d.cnt = 4'h0;
      d.take = 1'b0;
    end else if (sck_fall && !lock && q.cnt != 4'(`ADCCS_CFG_W)) begin
      // First edge decides; low data means read only
      take = (q.cnt == 4'h0) ? din : q.take;
      d.take = take;
      if (take) begin
        d.sh = {q.sh[`ADCCS_CFG_W-2:0], din};
      end
      d.cnt = q.cnt + 4'h1;
      // Word complete on the 14th edge
      d.load = take && (q.cnt == 4'(`ADCCS_CFG_W - 1));
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign load = q.load;
  assign word = q.sh;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b || !ce);

  property p_load_14;
    q.load |-> q.cnt == 4'he && $past(q.cnt) == 4'hd;
  endproperty
  a_load_14: assert property (p_load_14)
    else $error("load not on 14th edge");

  property p_lock_hold;
    lock && sck_fall && !frame |=> $stable(q.cnt) && !q.load;
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("edge counted while locked");

  property p_low_first;
    sck_fall && !lock && !frame && q.cnt == 4'h0 && !din |=> !q.take;
  endproperty
  a_low_first: assert property (p_low_first)
    else $error("low first bit started update");

  c_load: cover property (q.load);

endmodule // adccs_cfg_shift
`default_nettype wire

// ==== design/adccs_top.sv ====
// Converter control: sync, conversion timer, config apply, sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "adccs_consts.svh"
module adccs_top
  import adccs_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `ADCCS_TCONV_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic convert_start,
  input wire logic sck,
  input wire logic din,
  output logic conv_busy,
  output logic [`ADCCS_CFG_W-1:0] cfg_word,
  output logic seq_active,
  output logic [2:0] mux_pos,
  output logic [2:0] mux_neg,
  output logic neg_pair,
  output logic neg_com,
  output logic temp_sel,
  output logic quarter_bw,
  output logic ref_int_en,
  output logic ref_4v096,
  output logic ref_buf_en,
  output logic temp_sensor_en,
  output logic straight_binary
);

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  // Reference scheme: {int_en, 4v096, buf_en, temp_en}
  function automatic logic [3:0] ref_dec(input logic [2:0] r);
    unique case (r)
      `ADCCS_REF_INT2V5: ref_dec = 4'hb;
      `ADCCS_REF_INT4V096: ref_dec = 4'hf;
      `ADCCS_REF_EXT_T: ref_dec = 4'h1;
      `ADCCS_REF_EXTBUF_T: ref_dec = 4'h3;
      `ADCCS_REF_EXT: ref_dec = 4'h0;
      `ADCCS_REF_EXTBUF: ref_dec = 4'h2;
      // Undefined codes power everything down
      default: ref_dec = 4'h0;
    endcase
  endfunction

  // Paired inputs when the middle input-config bit is low
  function automatic logic is_paired(input logic [`ADCCS_CFG_W-1:0] c);
    is_paired = !c[`ADCCS_PAIR_BIT];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  adccs_state_t q, d; // Whole block state and next value
  logic cnv_rise; // Start of a conversion frame
  logic sck_fall; // Falling serial clock
  logic conv_end; // Conversion time over
  logic ld; // Word loaded by the serial loader
  logic [`ADCCS_CFG_W-1:0] ld_word; // Loaded word
  logic [2:0] last; // Last channel field
  logic paired; // Pair mode of the active word
  logic at_last; // Sequencer sits on the last slot
  logic [2:0] nmode; // Mode field of the pending word, padded
  logic restart; // Sequence goes back to input 0
  logic seq_on; // Sequencer scanning

  // Edges on synchronised pins only; stage 1 feeds stage 2 alone
  assign cnv_rise = q.cnv_s2 && !q.cnv_s3;
  assign sck_fall = !q.sck_s2 && q.sck_s3;
  assign conv_end = (q.st == ADCCS_CONV) &&
                    (q.cnt == `ADCCS_CNT_W'(CONV_CYCLES - 1));
  assign last = q.cfg[`ADCCS_LAST_HI:`ADCCS_LAST_LO];
  assign paired = is_paired(q.cfg);
  assign seq_on = q.mode[1];

  // ----------------------------------------
  // Serial loader
  // ----------------------------------------
  adccs_cfg_shift u_shift (
    .mclk(mclk),
    .rst_b(rst_b),
    .ce(ce),
    .frame(cnv_rise),
    .sck_fall(sck_fall),
    .din(q.din_s2),
    .lock(q.locked),
    .load(ld),
    .word(ld_word)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    nmode = {1'b0, q.pend[`ADCCS_SEQ_HI:`ADCCS_SEQ_LO]};
    restart = 1'b0;
    at_last = paired ? (q.chan[2:1] == last[2:1]) : (q.chan == last);
    d.restarted = 1'b0;

    // Two-stage synchronisers for the pins
    d.cnv_s1 = convert_start;
    d.cnv_s2 = q.cnv_s1;
    d.cnv_s3 = q.cnv_s2;
    d.sck_s1 = sck;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.din_s1 = din;
    d.din_s2 = q.din_s1;

    // Conversion timer; a second start while busy is ignored
    unique case (q.st)
      ADCCS_IDLE: begin
        if (cnv_rise) begin
          d.st = ADCCS_CONV;
          d.cnt = '0;
          // Advance one slot per started conversion
          if (seq_on) begin
            if (q.tslot) begin
              d.tslot = 1'b0;
              d.chan = 3'h0;
            end else if (at_last) begin
              // Temperature once after the last channel
              if (q.mode == `ADCCS_SEQ_SCANT) begin
                d.tslot = 1'b1;
              end else begin
                d.chan = 3'h0;
              end
            end else begin
              d.chan = q.chan + (paired ? 3'h2 : 3'h1);
            end
          end
        end
      end
      ADCCS_CONV: begin
        d.cnt = q.cnt + `ADCCS_CNT_W'(1);
        if (conv_end) begin
          d.st = ADCCS_IDLE;
          d.locked = 1'b0;
          // Pending word applies to the next acquisition
          if (q.pend_v) begin
            d.pend_v = 1'b0;
            d.cfg = q.pend;
            if (nmode[1:0] == `ADCCS_SEQ_UPD) begin
              // Keep scanning with new settings
              restart = (q.pend[`ADCCS_PAIR_BIT] !=
                         q.cfg[`ADCCS_PAIR_BIT]) ||
                        (q.pend[`ADCCS_LAST_HI:`ADCCS_LAST_LO] !=
                         last);
            end else begin
              // Any other mode value initialises
              d.mode = nmode[1:0];
              restart = 1'b1;
            end
            if (restart) begin
              // Sequence always starts at input 0
              d.chan = 3'h0;
              d.tslot = 1'b0;
              d.restarted = 1'b1;
            end
          end
        end
      end
    endcase

    // Loaded word waits; further data ignored until conversion ends.
    // Placed after the timer so the lock set beats the unlock there.
    if (ld) begin
      d.pend = ld_word;
      d.pend_v = 1'b1;
      d.locked = 1'b1;
    end

    // Mux and front-end controls from the active settings
    if (seq_on) begin
      // Even input positive, odd negative in pairs
      d.pos = paired ? {q.chan[2:1], 1'b0} : q.chan;
      d.neg = paired ? {q.chan[2:1], 1'b1} : 3'h0;
      d.temp_sel = q.tslot;
    end else begin
      // Sequencer off: the channel field selects directly
      d.pos = last;
      d.neg = paired ? (last ^ 3'h1) : 3'h0;
      d.temp_sel = q.cfg[`ADCCS_INPUT_CONFIG_FIELD_HI:`ADCCS_INPUT_CONFIG_FIELD_LO] ==
                   `ADCCS_INPUT_CONFIG_FIELD_TEMP;
    end
    d.neg_pair = paired;
    d.neg_com = !paired && (q.cfg[`ADCCS_INPUT_CONFIG_FIELD_HI:`ADCCS_INPUT_CONFIG_FIELD_LO] !=
                            `ADCCS_INPUT_CONFIG_FIELD_GND);
    d.quarter_bw = !q.cfg[`ADCCS_BW_BIT];
    d.refd = ref_dec(q.cfg[`ADCCS_REF_HI:`ADCCS_REF_LO]);
    // Sensor result is ground referred, straight binary
    d.straight = d.temp_sel || q.cfg[`ADCCS_INPUT_CONFIG_FIELD_HI];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Clock enable low freezes everything, synchronisers included
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      q <= '0;
      q.cfg <= `ADCCS_CFG_RST;
      q.mode <= `ADCCS_SEQ_SCAN;
      q.quarter_bw <= 1'b0;
      q.refd <= 4'h2;
      q.straight <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign conv_busy = (q.st == ADCCS_CONV);
  assign cfg_word = q.cfg;
  assign seq_active = seq_on;
  assign mux_pos = q.pos;
  assign mux_neg = q.neg;
  assign neg_pair = q.neg_pair;
  assign neg_com = q.neg_com;
  assign temp_sel = q.temp_sel;
  assign quarter_bw = q.quarter_bw;
  assign ref_int_en = q.refd[3];
  assign ref_4v096 = q.refd[2];
  assign ref_buf_en = q.refd[1];
  assign temp_sensor_en = q.refd[0];
  assign straight_binary = q.straight;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b || !ce);

  property p_pair_even;
    seq_on && paired && !q.tslot |=> !mux_pos[0] && mux_neg[0];
  endproperty
  a_pair_even: assert property (p_pair_even)
    else $error("pair polarity wrong");

  property p_restart_zero;
    q.restarted |-> q.chan == 3'h0 && !q.tslot;
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("restart not at input 0");

  property p_temp_after_last;
    seq_on && q.mode == `ADCCS_SEQ_SCANT && at_last && !q.tslot &&
      cnv_rise && q.st == ADCCS_IDLE |=> q.tslot;
  endproperty
  a_temp_after_last: assert property (p_temp_after_last)
    else $error("temperature slot missed");

  property p_cfg_at_end;
    $changed(q.cfg) |-> $past(conv_end) && $past(q.pend_v);
  endproperty
  a_cfg_at_end: assert property (p_cfg_at_end)
    else $error("settings changed mid conversion");

  property p_busy_len;
    q.st == ADCCS_IDLE && cnv_rise |=> conv_busy [*8];
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("conversion ended early");

  property p_int_ref_temp;
    q.cfg[`ADCCS_REF_HI:`ADCCS_REF_LO+1] == 2'h0 |=> temp_sensor_en;
  endproperty
  a_int_ref_temp: assert property (p_int_ref_temp)
    else $error("sensor off with internal reference");

  property p_bw;
    ##1 quarter_bw == !$past(q.cfg[`ADCCS_BW_BIT]);
  endproperty
  a_bw: assert property (p_bw)
    else $error("bandwidth select wrong");

  // A word loaded on the last busy cycle must still lock the loader
  property p_load_locks;
    ld |=> q.locked && q.pend_v;
  endproperty
  a_load_locks: assert property (p_load_locks)
    else $error("loaded word left unlocked");

  // Single inputs step by one on each started conversion short of the last slot
  property p_step_one;
    q.st == ADCCS_IDLE && cnv_rise && seq_on && !paired && !q.tslot &&
      !at_last |=> q.chan == $past(q.chan) + 3'h1;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("slot did not step by one");

  c_wrap: cover property (seq_on && q.tslot ##1 q.chan == 3'h0);
  c_update: cover property (conv_end && q.pend_v &&
                            nmode[1:0] == `ADCCS_SEQ_UPD);
  c_restart: cover property (q.restarted && seq_on);

endmodule // adccs_top
`default_nettype wire

// ==== testbench/adccs_host.sv ====
// Host model: starts conversions and writes the configuration word.
`timescale 1ns/10ps
`default_nettype none
module adccs_host (
  input wire logic mclk,
  output logic convert_start,
  output logic sck,
  output logic din
);
  // Pins idle low; serial clock stands still outside frames
  initial begin
    convert_start = 1'b0;
    sck = 1'b0;
    din = 1'b0;
  end

  // One frame: start pulse, then n bits of w, MSB first
  task automatic conv(input logic [15:0] w, input int n);
    @(negedge mclk);
    convert_start = 1'b1;
    repeat (4) @(negedge mclk);
    convert_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      // Bit 13 first decides update or not
      din = w[15-i];
      sck = 1'b1;
      repeat (4) @(negedge mclk);
      // Falling edge shifts; slow enough for the synchronisers
      sck = 1'b0;
      repeat (4) @(negedge mclk);
    end
    // Data kept low after the word so no new update starts
    din = 1'b0;
  endtask
endmodule // adccs_host
`default_nettype wire

// ==== testbench/test_adc_channel_sequencer.sv ====
// Self-checking bench of the channel sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "adccs_consts.svh"
module test_adc_channel_sequencer;
  logic mclk, rst_b, ce, convert_start, sck, din;
  logic conv_busy, seq_active, neg_pair, neg_com, temp_sel;
  logic quarter_bw, ref_int_en, ref_4v096, ref_buf_en;
  logic temp_sensor_en, straight_binary;
  logic [13:0] cfg_word;
  logic [2:0] mux_pos, mux_neg;
  logic [7:0] fe; // Front-end flags in one vector
  int fail_count = 0;
  int check_count = 0;
  int k;

  // Row: word, flags, flag mask, first pos, first neg, {pair, com}
  typedef struct packed {
    logic [13:0] w;
    logic [7:0] e;
    logic [7:0] m;
    logic [2:0] p;
    logic [2:0] n;
    logic [1:0] g;
  } adccs_row_t;
  // Masked flags are design choices that the rules leave open
  adccs_row_t rows [6] = '{
    '{14'h3fc7, 8'h93, 8'hfb, 3'h0, 3'h0, 2'h0},
    '{14'h228d, 8'hba, 8'hfb, 3'h0, 3'h1, 2'h2},
    '{14'h3957, 8'h83, 8'hef, 3'h0, 3'h0, 2'h1},
    '{14'h285f, 8'h86, 8'hef, 3'h0, 3'h0, 2'h1},
    '{14'h3531, 8'h21, 8'hff, 3'h2, 3'h3, 2'h2},
    '{14'h2e79, 8'h45, 8'hff, 3'h4, 3'h0, 2'h1}};

  assign fe = {seq_active, temp_sel, quarter_bw, ref_int_en,
    ref_4v096, ref_buf_en, temp_sensor_en, straight_binary};

  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  // Long conversion so a full word fits inside one conversion
  adccs_top #(.CONV_CYCLES(150)) dut (
    .mclk, .rst_b, .ce, .convert_start, .sck, .din, .conv_busy,
    .cfg_word, .seq_active, .mux_pos, .mux_neg, .neg_pair, .neg_com,
    .temp_sel, .quarter_bw, .ref_int_en, .ref_4v096, .ref_buf_en,
    .temp_sensor_en, .straight_binary);
  adccs_host host (.mclk, .convert_start, .sck, .din);

  // Clock at 25 MHz
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input string s, input logic [13:0] g, e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic conclude;
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Reset for 10 cycles, then look at the reset state
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    chk("cfg_word", cfg_word, 14'h3fff);
    chk("front_end", fe, 8'h85);
    chk("mux_pos", mux_pos, 3'h0);
    chk("conv_busy", conv_busy, 1'b0);
  endtask

  // One conversion with an optional word; bounded wait for its end
  task automatic run(input logic [15:0] w, input int n);
    logic [13:0] old;
    int i;
    old = cfg_word;
    host.conv(w, n);
    chk("cfg_held", cfg_word, old);
    for (i = 0; i < 400 && conv_busy !== 1'b0; i++)
      @(negedge mclk);
    if (i == 400) begin
      fail_count++;
      conclude();
    end
    // Mux outputs follow one edge after the applied word
    repeat (2) @(negedge mclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ce = 1'b1;
    do_reset();
    // Default word scans singles 0..7 and wraps
    for (k = 1; k <= 9; k++) begin
      run(16'h0, 0);
      chk("mux_pos", mux_pos, 14'(k % 8));
    end
    // Table of words: front-end decode and sequence start
    foreach (rows[r]) begin
      run({rows[r].w, 2'h0}, 14);
      chk("cfg_word", cfg_word, rows[r].w);
      chk("front_end", fe & rows[r].m,
      rows[r].e & rows[r].m);
      chk("neg_sel", {neg_pair, neg_com}, rows[r].g);
      chk("mux_pos", mux_pos, rows[r].p);
      chk("mux_neg", mux_neg, rows[r].n);
    end
    // Pairs up to 3, then the temperature slot, then wrap
    run({14'h31c5, 2'h0}, 14);
    chk("pair", {temp_sel, mux_pos, mux_neg}, 7'h01);
    run(16'h0, 0);
    chk("pair", {temp_sel, mux_pos, mux_neg}, 7'h13);
    run(16'h0, 0);
    chk("temp_sel", temp_sel, 1'b1);
    run(16'h0, 0);
    chk("pair", {temp_sel, mux_pos, mux_neg}, 7'h01);
    // Mid-run reset, then updates during a sequence
    do_reset();
    repeat (3) run(16'h0, 0);
    run({14'h3ffb, 2'h0}, 14);
    chk("mux_pos", mux_pos, 3'h4);
    run({14'h3dfb, 2'h0}, 14);
    chk("mux_pos", mux_pos, 3'h0);
    // Low first bit leaves the word alone
    run({14'h1fc7, 2'h0}, 14);
    chk("cfg_word", cfg_word, 14'h3dfb);
    // Edges past the fourteenth are ignored
    run({14'h3fc7, 2'h3}, 16);
    chk("cfg_word", cfg_word, 14'h3fc7);
    // Clock enable low freezes the block; a start then is not seen
    ce = 1'b0;
    host.conv(16'h0, 0);
    repeat (8) @(negedge mclk);
    chk("frozen_busy", conv_busy, 1'b0);
    ce = 1'b1;
    repeat (8) @(negedge mclk);
    chk("frozen_cfg", cfg_word, 14'h3fc7);
    chk("frozen_busy", conv_busy, 1'b0);
    conclude();
  end
endmodule // test_adc_channel_sequencer
`default_nettype wire
